// File: src/csf_defines.vh
// Register offsets, field positions, reset values and timing counts for the carrier sense and freeze block
`ifndef CSF_DEFINES_VH
`define CSF_DEFINES_VH
`define CSF_OFF_CONFIG      8'h11
`define CSF_OFF_STATUS      8'h20
`define CSF_OFF_IRQ_STATUS  8'h21
`define CSF_OFF_IRQ_MASK    8'h22
`define CSF_OFF_DIVISOR     8'h23
`define CSF_CFG_RESET       8'h75
`define CSF_DIV_RESET       5'h00
`define CSF_MASK_RESET      3'h0
`define CSF_IRQ_RESET       3'h0
`define CSF_F_SETCNT_HI     7
`define CSF_F_SETCNT_LO     6
`define CSF_F_CLRCNT        5
`define CSF_F_WAIT_HI       4
`define CSF_F_WAIT_LO       2
`define CSF_F_EXTRA_HI      1
`define CSF_F_EXTRA_LO      0
`define CSF_WAIT_FOREVER    3'h7
`define CSF_WAIT_LEN0       6'h10
`define CSF_WAIT_LEN1       6'h14
`define CSF_WAIT_LEN2       6'h18
`define CSF_WAIT_LEN3       6'h1C
`define CSF_WAIT_LEN4       6'h20
`define CSF_WAIT_LEN5       6'h28
`define CSF_WAIT_LEN6       6'h30
`define CSF_EXTRA_BASE      8'h10
`define CSF_BASE_DIV        16'h0010
`define CSF_ADC_DIV         16'h0008
`define CSF_IRQ_CS_ON       0
`define CSF_IRQ_CS_OFF      1
`define CSF_IRQ_FRZ_DONE    2
`endif

// File: src/csf_sync3.v
// Three flip-flop input synchroniser with agreement check
`timescale 1ns/100ps
`default_nettype none
module csf_sync3
(
  input  wire mclk,
  input  wire rst,
  input  wire din,
  output reg  dout
);
  reg s1;
  reg s2;
  reg s3;

  // Stage chain; output moves only when the second and third stage agree
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        dout <= s3;
    end
  end
endmodule // csf_sync3
`default_nettype wire

// File: src/csf_tick_div.v
// Programmable tick generator: one pulse every divisor cycles
`timescale 1ns/100ps
`default_nettype none
module csf_tick_div
#(
  parameter WIDTH = 16
)
(
  input  wire             mclk,
  input  wire             rst,
  input  wire [WIDTH-1:0] divisor,
  output reg              tick
);
  reg [WIDTH-1:0] count;

  // Counts down from divisor-1, pulses at zero
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count <= {WIDTH{1'b0}};
      tick  <= 1'b0;
    end
    else if (count == {WIDTH{1'b0}})
    begin
      count <= divisor - {{(WIDTH-1){1'b0}}, 1'b1};
      tick  <= 1'b1;
    end
    else
    begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      tick  <= 1'b0;
    end
  end
endmodule // csf_tick_div
`default_nettype wire

// File: src/csf_carrier_freeze.v
// Carrier sense qualifier and post-event level freeze controller
// What this block does
// - Carrier sense asserts after assert-count plus one consecutive samples at or above level
// - Carrier sense clears after one or two consecutive samples below level
// - Freeze gain, sync, frequency and strength levels after channel switch, unlock, power-up
// - Wait codes 0 to 6 give 16,20,24,28,32,40,48 filter clocks
// - Wait code 7 holds levels frozen indefinitely
// - Extra freeze of 16,32,64,128 converter clock periods follows
// - Filter clock rate is base rate divided by decimation divisor plus one
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "csf_defines.vh"
module csf_carrier_freeze
#(
  parameter BASE_DIV = `CSF_BASE_DIV,
  parameter ADC_DIV  = `CSF_ADC_DIV
)
(
  input  wire       mclk,
  input  wire       rst,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWr,
  input  wire       regRd,
  output reg  [7:0] regRdData,
  input  wire       sampleValid,
  input  wire       sampleAbove,
  input  wire       chanSwitch,
  input  wire       pllUnlock,
  input  wire       rxPowerUp,
  output reg        carrierSense,
  output reg        freezeLevels,
  output reg        irq
);
  // Configuration and control registers
  reg  [7:0] carrier_sense_and_freeze_config;
  reg  [4:0] decimation_divisor;
  reg  [2:0] irqStatus;
  reg  [2:0] irqMask;
  // Carrier sense state
  reg  [1:0] aboveRun;
  reg        belowRun;
  // Freeze state
  reg  [1:0] phase;
  reg  [5:0] waitCnt;
  reg  [7:0] extraCnt;
  reg  [2:0] trigSeen;
  // Event pulses
  reg        csOnEv;
  reg        csOffEv;
  reg        frzDoneEv;
  // Synchronised trigger levels
  wire       syncSwitch;
  wire       syncUnlock;
  wire       syncPowerUp;
  wire       filterTick;
  wire       adcTick;
  wire [1:0] setCnt;
  wire       clrCnt;
  wire [2:0] waitCode;
  wire [1:0] extraCode;
  wire       trigger;
  reg  [5:0] waitLen;
  reg  [7:0] extraLen;
  reg  [15:0] filterDiv;

  localparam PH_IDLE  = 2'h0;
  localparam PH_WAIT  = 2'h1;
  localparam PH_EXTRA = 2'h2;
  localparam PH_HOLD  = 2'h3;

  assign setCnt    = carrier_sense_and_freeze_config[`CSF_F_SETCNT_HI:`CSF_F_SETCNT_LO];
  assign clrCnt    = carrier_sense_and_freeze_config[`CSF_F_CLRCNT];
  assign waitCode  = carrier_sense_and_freeze_config[`CSF_F_WAIT_HI:`CSF_F_WAIT_LO];
  assign extraCode = carrier_sense_and_freeze_config[`CSF_F_EXTRA_HI:`CSF_F_EXTRA_LO];

  // Trigger inputs arrive from other clock domains
  csf_sync3 uSyncSwitch
  (
    .mclk (mclk),
    .rst  (rst),
    .din  (chanSwitch),
    .dout (syncSwitch)
  );
  csf_sync3 uSyncUnlock
  (
    .mclk (mclk),
    .rst  (rst),
    .din  (pllUnlock),
    .dout (syncUnlock)
  );
  csf_sync3 uSyncPowerUp
  (
    .mclk (mclk),
    .rst  (rst),
    .din  (rxPowerUp),
    .dout (syncPowerUp)
  );

  // Filter clock period scales with the decimation divisor
  always @*
  begin
    filterDiv = BASE_DIV[15:0] * {11'h000, decimation_divisor + 5'h01};
    if (decimation_divisor == 5'h1F)
      filterDiv = BASE_DIV[15:0] * 16'h0020;
  end

  csf_tick_div #(.WIDTH(16)) uFilterTick
  (
    .mclk    (mclk),
    .rst     (rst),
    .divisor (filterDiv),
    .tick    (filterTick)
  );
  csf_tick_div #(.WIDTH(16)) uAdcTick
  (
    .mclk    (mclk),
    .rst     (rst),
    .divisor (ADC_DIV[15:0]),
    .tick    (adcTick)
  );

  // Rising edge of any synchronised trigger level
  assign trigger = (syncSwitch & ~trigSeen[0]) | (syncUnlock & ~trigSeen[1]) | (syncPowerUp & ~trigSeen[2]);

  // Phase lengths from the configuration codes
  always @*
  begin
    case (waitCode)
      3'h0:    waitLen = `CSF_WAIT_LEN0;
      3'h1:    waitLen = `CSF_WAIT_LEN1;
      3'h2:    waitLen = `CSF_WAIT_LEN2;
      3'h3:    waitLen = `CSF_WAIT_LEN3;
      3'h4:    waitLen = `CSF_WAIT_LEN4;
      3'h5:    waitLen = `CSF_WAIT_LEN5;
      3'h6:    waitLen = `CSF_WAIT_LEN6;
      default: waitLen = `CSF_WAIT_LEN6;
    endcase
    extraLen = `CSF_EXTRA_BASE << extraCode;
  end

  // Carrier sense run counters
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      aboveRun     <= 2'h0;
      belowRun     <= 1'b0;
      carrierSense <= 1'b0;
      csOnEv       <= 1'b0;
      csOffEv      <= 1'b0;
    end
    else
    begin
      csOnEv  <= 1'b0;
      csOffEv <= 1'b0;
      if (sampleValid)
      begin
        if (sampleAbove)
        begin
          belowRun <= 1'b0;
          if (!carrierSense)
          begin
            if (aboveRun == setCnt)
            begin
              carrierSense <= 1'b1;
              csOnEv       <= 1'b1;
              aboveRun     <= 2'h0;
            end
            else
              aboveRun <= aboveRun + 2'h1;
          end
        end
        else
        begin
          aboveRun <= 2'h0;
          if (carrierSense)
          begin
            if (belowRun == clrCnt)
            begin
              carrierSense <= 1'b0;
              csOffEv      <= 1'b1;
              belowRun     <= 1'b0;
            end
            else
              belowRun <= 1'b1;
          end
        end
      end
    end
  end

  // Freeze sequencer: wait phase in filter clocks, then extra phase in converter clocks
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      phase        <= PH_IDLE;
      waitCnt      <= 6'h00;
      extraCnt     <= 8'h00;
      freezeLevels <= 1'b0;
      frzDoneEv    <= 1'b0;
      trigSeen     <= 3'h0;
    end
    else
    begin
      trigSeen  <= {syncPowerUp, syncUnlock, syncSwitch};
      frzDoneEv <= 1'b0;
      if (waitCode == `CSF_WAIT_FOREVER)
      begin
        phase        <= PH_HOLD;
        freezeLevels <= 1'b1;
      end
      else if (trigger)
      begin
        phase        <= PH_WAIT;
        waitCnt      <= 6'h00;
        extraCnt     <= 8'h00;
        freezeLevels <= 1'b1;
      end
      else
      begin
        case (phase)
          PH_WAIT:
          begin
            if (filterTick)
            begin
              if (waitCnt + 6'h01 >= waitLen)
                phase <= PH_EXTRA;
              waitCnt <= waitCnt + 6'h01;
            end
          end
          PH_EXTRA:
          begin
            if (adcTick)
            begin
              if (extraCnt + 8'h01 >= extraLen)
              begin
                phase        <= PH_IDLE;
                freezeLevels <= 1'b0;
                frzDoneEv    <= 1'b1;
              end
              extraCnt <= extraCnt + 8'h01;
            end
          end
          PH_HOLD:
          begin
            phase        <= PH_IDLE;
            freezeLevels <= 1'b0;
            frzDoneEv    <= 1'b1;
          end
          default:
            freezeLevels <= 1'b0;
        endcase
      end
    end
  end

  // Register writes; sticky status set wins over write-one clear
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      carrier_sense_and_freeze_config <= `CSF_CFG_RESET;
      decimation_divisor <= `CSF_DIV_RESET;
      irqMask            <= `CSF_MASK_RESET;
      irqStatus          <= `CSF_IRQ_RESET;
    end
    else
    begin
      if (regWr && regAddr == `CSF_OFF_CONFIG)
        carrier_sense_and_freeze_config <= regWrData;
      if (regWr && regAddr == `CSF_OFF_DIVISOR)
        decimation_divisor <= regWrData[4:0];
      if (regWr && regAddr == `CSF_OFF_IRQ_MASK)
        irqMask <= regWrData[2:0];
      irqStatus <= ((regWr && regAddr == `CSF_OFF_IRQ_STATUS) ? (irqStatus & ~regWrData[2:0]) : irqStatus)
                   | {frzDoneEv, csOffEv, csOnEv};
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      regRdData <= 8'h00;
      irq       <= 1'b0;
    end
    else
    begin
      irq       <= |(irqStatus & irqMask);
      regRdData <= 8'h00;
      if (regRd)
      begin
        case (regAddr)
          `CSF_OFF_CONFIG:     regRdData <= carrier_sense_and_freeze_config;
          `CSF_OFF_STATUS:     regRdData <= {4'h0, phase, freezeLevels, carrierSense};
          `CSF_OFF_IRQ_STATUS: regRdData <= {5'h00, irqStatus};
          `CSF_OFF_IRQ_MASK:   regRdData <= {5'h00, irqMask};
          `CSF_OFF_DIVISOR:    regRdData <= {3'h0, decimation_divisor};
          default:             regRdData <= 8'h00;
        endcase
      end
    end
  end
endmodule // csf_carrier_freeze
`default_nettype wire

// File: tb/csf_carrier_freeze_properties.sv
// Port checks for the carrier sense and freeze block
`timescale 1ns/100ps
`default_nettype none
`include "csf_defines.vh"
module csf_carrier_freeze_properties
(
  input wire       mclk,
  input wire       rst,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire       regWr,
  input wire       regRd,
  input wire [7:0] regRdData,
  input wire       sampleValid,
  input wire       sampleAbove,
  input wire       chanSwitch,
  input wire       pllUnlock,
  input wire       rxPowerUp,
  input wire       carrierSense,
  input wire       freezeLevels,
  input wire       irq
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Trigger rise, held freeze and hold-code write
  sequence trigSeen;
    $rose(chanSwitch) || $rose(pllUnlock) || $rose(rxPowerUp);
  endsequence
  sequence heldRun;
    freezeLevels [*8];
  endsequence
  sequence holdCode;
    regWr && regAddr == `CSF_OFF_CONFIG && regWrData[4:2] == `CSF_WAIT_FOREVER;
  endsequence
  // Read data only in its slot
  rd_idle_a: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("stray data");
  rd_status_a: assert property ($past(regRd) && $past(regAddr) == `CSF_OFF_STATUS
    |-> regRdData[1:0] == {$past(freezeLevels), $past(carrierSense)}) else $error("bad status");
  // Carrier sense moves only on a sample
  cs_set_a: assert property (
    $rose(carrierSense) |-> $past(sampleValid) && $past(sampleAbove)) else $error("bad set");
  cs_clr_a: assert property (
    $fell(carrierSense) |-> $past(sampleValid) && !$past(sampleAbove)) else $error("bad clear");
  cs_quiet_a: assert property (
    !$past(sampleValid) |-> $stable(carrierSense)) else $error("idle move");
  // Freeze follows triggers and lasts
  frz_trig_a: assert property (
    trigSeen |-> ##[1:8] freezeLevels) else $error("no freeze");
  frz_hold_a: assert property (
    trigSeen ##8 1'h1 |-> heldRun) else $error("freeze cut");
  frz_min_a: assert property (
    $rose(freezeLevels) |=> heldRun) else $error("freeze short");
  frz_code7_a: assert property (
    holdCode |-> ##[1:3] freezeLevels) else $error("no hold");
endmodule // csf_carrier_freeze_properties
bind csf_carrier_freeze csf_carrier_freeze_properties u_props
(
  .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .sampleValid(sampleValid), .sampleAbove(sampleAbove), .chanSwitch(chanSwitch),
  .pllUnlock(pllUnlock), .rxPowerUp(rxPowerUp), .carrierSense(carrierSense), .freezeLevels(freezeLevels),
  .irq(irq)
);
`default_nettype wire

// File: tb/test_csf_carrier_freeze.sv
// Self-checking bench for the carrier sense and freeze block
`timescale 1ns/100ps
`default_nettype none
module test_csf_carrier_freeze;
  logic       mclk = 1'h0, rst = 1'h1, regWr = 1'h0, regRd = 1'h0, rdPend = 1'h0;
  logic [1:0] smpIn = 2'h0;
  logic [2:0] trig = 3'h0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00;
  logic [7:0] expQ[$];
  wire  [7:0] regRdData;
  wire        carrierSense, freezeLevels, irq;
  int         err_total = 0, n_tests = 0, len, lo, p, div;
  int         waitTab[7] = '{16, 20, 24, 28, 32, 40, 48};
  // Clock
  always #5 mclk = ~mclk;
  csf_carrier_freeze #(.BASE_DIV(16), .ADC_DIV(8)) DUT
  (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .sampleValid(smpIn[1]), .sampleAbove(smpIn[0]), .chanSwitch(trig[0]),
    .pllUnlock(trig[1]), .rxPowerUp(trig[2]), .carrierSense(carrierSense), .freezeLevels(freezeLevels),
    .irq(irq)
  );
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // Read data checked against the oldest note
  always @(posedge mclk)
  begin
    if (rdPend)
      check(regRdData, expQ.pop_front());
    rdPend <= regRd;
  end
  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    @(posedge mclk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'h0;
  endtask
  // Magnitude samples, each valid one cycle, two cycles apart
  task automatic smp(input logic a, input int n);
    repeat (n)
    begin
      @(posedge mclk);
      smpIn <= {1'h1, a};
      @(posedge mclk);
      smpIn <= 2'h0;
    end
  endtask
  // Trigger one source and time the freeze
  task automatic frz(input int w, input int e, input int t);
    wr(8'h11, {3'h3, w[2:0], e[1:0]});
    trig <= 3'h1 << t;
    p = 16 * (div + 1);
    lo = waitTab[w] * p + (16 << e) * 8;
    len = 0;
    while ((len < 20 || freezeLevels) && len < 5000)
    begin
      @(posedge mclk);
      len++;
    end
    check({7'h00, len >= lo - p - 8 && len <= lo + p + 24}, 8'h01);
    trig <= 3'h0;
    repeat (3) @(posedge mclk);
    if (len >= 5000)
      final_report();
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Test sequence
  initial
  begin
    void'($urandom(24259));
    repeat (12) @(posedge mclk);
    rst <= 1'h0;
    rd(8'h11, 8'h75);
    rd(8'h22, 8'h00);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    $display("register test done");
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h11, {k[1:0], k[2], 5'h05});
      smp(1'h1, k % 4);
      smp(1'h0, 1);
      smp(1'h1, k % 4);
      rd(8'h20, 8'h00);
      smp(1'h1, 1);
      rd(8'h20, 8'h01);
      smp(1'h0, k / 4);
      smp(1'h1, 1);
      smp(1'h0, k / 4);
      rd(8'h20, 8'h01);
      smp(1'h0, 1);
      rd(8'h20, 8'h00);
    end
    $display("carrier test done");
    wr(8'h21, 8'hFF);
    wr(8'h22, 8'h04);
    for (int w = 0; w < 7; w++)
    begin
      div = $urandom_range(1, 0);
      wr(8'h23, div[7:0]);
      frz(w, w % 4, w % 3);
      check({7'h00, irq}, 8'h01);
      wr(8'h21, 8'h04);
      rd(8'h21, 8'h00);
      check({7'h00, irq}, 8'h00);
    end
    div = 0;
    wr(8'h23, 8'h00);
    trig <= 3'h2;
    repeat (150) @(posedge mclk);
    frz(0, 0, 0);
    $display("freeze test done");
    wr(8'h11, 8'h7D);
    trig <= 3'h4;
    repeat (2000) @(posedge mclk);
    check({7'h00, freezeLevels}, 8'h01);
    trig <= 3'h0;
    wr(8'h11, 8'h75);
    len = 0;
    while (freezeLevels && len < 1000)
    begin
      @(posedge mclk);
      len++;
    end
    check({7'h00, freezeLevels}, 8'h00);
    $display("hold test done");
    repeat (4) @(posedge mclk);
    final_report();
  end
endmodule // test_csf_carrier_freeze
`default_nettype wire
